// File: rtl/quad_decoder.v
// 4x edge quadrature decoder with optional direction-pin counting
`timescale 1ns/100ps

module quad_decoder (
   input  wire        clk,
   input  wire        rst,
   input  wire        phaseA,
   input  wire        phaseB,
   input  wire        dirIn,
   input  wire        useDirPin,
   output reg  [11:0] count_r,
   output reg         stepUp_r,
   output reg         stepDown_r
);

   // ****************************************************************
   // synchronisers
   // ****************************************************************
   reg [2:0] meta_r;
   reg [2:0] sync_r;
   reg [2:0] prev_r;
   wire      aS = sync_r[0];
   wire      bS = sync_r[1];
   wire      dS = sync_r[2];
   wire      aP = prev_r[0];
   wire      bP = prev_r[1];
   reg       up;
   reg       down;

   // two stages before any edge logic; meta_r only feeds sync_r
   always @(posedge clk) begin
      if (rst) begin
         meta_r <= 3'h0;
         sync_r <= 3'h0;
         prev_r <= 3'h0;
      end else begin
         meta_r <= {dirIn, phaseB, phaseA};
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   // edge/level decode of both phases
   always @* begin
      up   = ( aS & ~aP &  bS) | (~bS &  bP &  aS) |
             (~aS &  aP & ~bS) | ( bS & ~bP & ~aS);
      down = ( aS & ~aP & ~bS) | ( bS & ~bP &  aS) |
             (~aS &  aP &  bS) | (~bS &  bP & ~aS);
      if (useDirPin) begin
         // any edge counts, sense comes from the direction pin
         up   = (up | down) & dS;
         down = ((aS ^ aP) | (bS ^ bP)) & ~dS;
      end
   end

   // every edge of both phases is one lsb, four per cycle
   always @(posedge clk) begin
      if (rst) begin
         count_r    <= 12'h000;
         stepUp_r   <= 1'b0;
         stepDown_r <= 1'b0;
      end else begin
         stepUp_r   <= up;
         stepDown_r <= down;
         if (up)
            count_r <= count_r + 12'h001;
         else if (down)
            count_r <= count_r - 12'h001;
      end
   end

endmodule

// File: rtl/resolver_host.v
// host controller: serial angle reader plus quadrature position counter
`timescale 1ns/100ps
`include "resolver_host_map.vh"

// Functional notes
// - host shifting on same falling edge inverts the shift clock it delivers.
// - inverted-clock capture drops the first bit, keeps next twelve.
// - programmable-length inverted mode takes 13 bits and flags done.
// - fixed 16-bit inverted mode: void, twelve bits, three zeros, shift right three.
// - host expecting data on first falling edge inverts clock, one leading bit.
// - select comes from frame output; shift clock gated to the frame only.
// - rising-edge sampling keeps first bit valid; frame enable is select.
// - fixed 16-bit rising mode shifts right four and flags done after sixteen.
// - each A/B cycle is four one-lsb counts into a parallel word.
// - up and down counts follow the four edge/level combinations each.
// - count direction may come from the rotation-sense pin instead.
// - two address lines decode into at most one active select.
// - wait 600 ns after select low; shift clock no faster than 2 MHz.
// - hold select 100 ns after last edge, idle high 250 ns.
module resolver_host (
   input  wire        clk,
   input  wire        rst,
   input  wire        readReq,
   input  wire [1:0]  readMode,
   input  wire [1:0]  readAddr,
   output wire        readBusy,
   output reg         readDone_r,
   output reg  [11:0] angle_r,
   output reg         sclk_r,
   output wire [3:0]  selectN,
   input  wire        dataIn,
   input  wire        phaseA,
   input  wire        phaseB,
   input  wire        dirIn,
   input  wire        useDirPin,
   output wire [11:0] count,
   output wire        stepUp,
   output wire        stepDown
);

   // ****************************************************************
   // states and storage
   // ****************************************************************
   localparam [4:0] ST_IDLE  = 5'h01;
   localparam [4:0] ST_SETUP = 5'h02;
   localparam [4:0] ST_SHIFT = 5'h04;
   localparam [4:0] ST_HOLD  = 5'h08;
   localparam [4:0] ST_GAP   = 5'h10;

   reg  [4:0]  state_r;
   reg  [4:0]  state_nxt;
   reg  [7:0]  timer_r;
   reg  [4:0]  bitCnt_r;
   reg  [15:0] host_receive_shifter_r;
   reg  [1:0]  mode_r;
   reg  [1:0]  addr_r;
   reg         frame_r;       // host_frame_enable, drives the select
   reg         dataMeta_r;
   reg         dataSync_r;
   wire [11:0] host_receive_word;

   // word length of each receive style
   function [4:0] wordLen;
      input [1:0] m;
      begin
         if (m == `MODE_INV13)
            wordLen = `LEN_13;
         else
            wordLen = `LEN_16;
      end
   endfunction

   // align a received word to the twelve significant bits
   function [11:0] alignWord;
      input [1:0]  m;
      input [15:0] w;
      begin
         case (m)
            `MODE_INV13: alignWord = w[11:0];                    // void bit dropped
            `MODE_INV16: alignWord = w[`SHIFT_INV16 +: 12];
            default:     alignWord = w[`SHIFT_RISE16 +: 12];
         endcase
      end
   endfunction

   // ****************************************************************
   // timer reloads
   // ****************************************************************
   // the timer runs down to zero inclusive, so each reload is one short
   localparam integer SETUP_LOAD_I = `SETUP_CYC - 1;
   localparam integer HALF_LOAD_I  = `SCLK_HALF_CYC - 1;
   localparam integer HOLD_LOAD_I  = `HOLD_CYC + `SCLK_HALF_CYC - 1;
   localparam integer GAP_LOAD_I   = `IDLE_CYC - 1;
   localparam [7:0]   SETUP_LOAD   = SETUP_LOAD_I[7:0];
   localparam [7:0]   HALF_LOAD    = HALF_LOAD_I[7:0];
   localparam [7:0]   HOLD_LOAD    = HOLD_LOAD_I[7:0];
   localparam [7:0]   GAP_LOAD     = GAP_LOAD_I[7:0];

   // aligned view of the shifter; only taken into angle_r at frame end
   assign host_receive_word = alignWord(mode_r, host_receive_shifter_r);

   assign readBusy = ~state_r[0];

   // one select at a time from the latched address
   assign selectN = ~({3'h0, frame_r} << addr_r);

   // data pin crosses in through two flops
   always @(posedge clk) begin
      if (rst) begin
         dataMeta_r <= 1'b0;
         dataSync_r <= 1'b0;
      end else begin
         dataMeta_r <= dataIn;
         dataSync_r <= dataMeta_r;
      end
   end

   // ****************************************************************
   // sequencer
   // ****************************************************************
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:  if (readReq) state_nxt = ST_SETUP;
         ST_SETUP: if (timer_r == 8'h00) state_nxt = ST_SHIFT;
         ST_SHIFT: if (timer_r == 8'h00 && sclk_r && bitCnt_r == 5'h00)
                      state_nxt = ST_HOLD;
         ST_HOLD:  if (timer_r == 8'h00) state_nxt = ST_GAP;
         ST_GAP:   if (timer_r == 8'h00) state_nxt = ST_IDLE;
         default:  state_nxt = ST_IDLE;
      endcase
   end

   // the device launches on its falling edges and every style samples on
   // the rising pin edge. The inverted styles make one extra capture just
   // before the first fall, while the device has not yet launched its msb:
   // that is the void bit, dropped again by the alignment. bitCnt_r counts
   // the captures still owed; the clock parks once it reaches zero.
   always @(posedge clk) begin
      if (rst) begin
         state_r                <= ST_IDLE;
         timer_r                <= 8'h00;
         bitCnt_r               <= 5'h00;
         host_receive_shifter_r <= 16'h0000;
         mode_r                 <= `MODE_RISE16;
         addr_r                 <= 2'h0;
         frame_r                <= 1'b0;
         sclk_r                 <= 1'b1;
         readDone_r             <= 1'b0;
         angle_r                <= 12'h000;
      end else begin
         state_r    <= state_nxt;
         readDone_r <= 1'b0;
         if (timer_r != 8'h00)
            timer_r <= timer_r - 8'h01;
         case (state_r)
            ST_IDLE: begin
               sclk_r <= 1'b1;
               if (readReq) begin
                  mode_r   <= readMode;
                  addr_r   <= readAddr;
                  frame_r  <= 1'b1;
                  bitCnt_r <= wordLen(readMode);
                  timer_r  <= SETUP_LOAD;
               end
            end
            ST_SETUP: begin
               if (timer_r == 8'h00) begin
                  // first low half: a pin falling edge for the device
                  sclk_r  <= 1'b0;
                  timer_r <= HALF_LOAD;
                  if (mode_r == `MODE_INV13 || mode_r == `MODE_INV16) begin
                     // void capture ahead of the first fall
                     host_receive_shifter_r <= {host_receive_shifter_r[14:0], dataSync_r};
                     bitCnt_r               <= bitCnt_r - 5'h01;
                  end
               end
            end
            ST_SHIFT: begin
               if (timer_r == 8'h00) begin
                  sclk_r  <= ~sclk_r;
                  timer_r <= HALF_LOAD;
                  if (!sclk_r) begin
                     // sample on rising clock, data stable since the fall
                     host_receive_shifter_r <= {host_receive_shifter_r[14:0], dataSync_r};
                     bitCnt_r               <= bitCnt_r - 5'h01;
                  end else if (bitCnt_r == 5'h00) begin
                     sclk_r  <= 1'b1;                            // gated: clock parks high
                     timer_r <= HOLD_LOAD;
                  end
               end
            end
            ST_HOLD: begin
               if (timer_r == 8'h00) begin
                  frame_r           <= 1'b0;
                  timer_r           <= GAP_LOAD;
                  angle_r           <= host_receive_word;
                  readDone_r        <= 1'b1;
               end
            end
            ST_GAP: ;
            default: frame_r <= 1'b0;
         endcase
      end
   end

   // ****************************************************************
   // incremental path
   // ****************************************************************
   quad_decoder u_quad (
      .clk        (clk),
      .rst        (rst),
      .phaseA     (phaseA),
      .phaseB     (phaseB),
      .dirIn      (dirIn),
      .useDirPin  (useDirPin),
      .count_r    (count),
      .stepUp_r   (stepUp),
      .stepDown_r (stepDown)
   );

endmodule

// File: rtl/resolver_host_map.vh
// timing and framing constants for the resolver position host
`ifndef RESOLVER_HOST_MAP_VH
`define RESOLVER_HOST_MAP_VH

// ****************************************************************
// clock and timing
// ****************************************************************
`define CLK_PERIOD_NS      25
`define SETUP_NS           600
`define SETUP_CYC          ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCLK_PERIOD_NS     500
`define SCLK_HALF_CYC      ((`SCLK_PERIOD_NS / 2 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_NS            100
`define HOLD_CYC           ((`HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IDLE_NS            250
`define IDLE_CYC           ((`IDLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************************************************************
// word framing
// ****************************************************************
`define POS_BITS           12
`define MODE_RISE16        2'h0
`define MODE_INV13         2'h1
`define MODE_INV16         2'h2
`define LEN_13             5'h0d
`define LEN_16             5'h10
`define SHIFT_INV16        3
`define SHIFT_RISE16       4
`define COUNT_BITS         12

`endif

// File: verification/resolver_device.sv
// behavioural model of four converters sharing the serial data line
`timescale 1ns/100ps
module resolver_device (
   input  wire [3:0]  selectN,
   input  wire        sclk,
   input  wire [47:0] angles,
   output reg         dataOut,
   output reg         dataEn
);
   reg [11:0] sh;
   integer    i;
   initial dataOut = 1'b0;
   // select edge: latch the angle; data is not valid before the first falling clock edge
   always @(selectN) begin
      dataEn = ~&selectN;
      for (i = 0; i < 4; i = i + 1)
         if (!selectN[i]) sh = angles[i*12 +: 12];
      dataOut = ~dataOut; // released line keeps no value
   end
   // msb first on falling edges, zeros once the word is out
   always @(negedge sclk) begin
      if (dataEn) begin
         dataOut = sh[11];
         sh = {sh[10:0], 1'b0};
      end
   end
endmodule

// File: verification/resolver_host_bench.sv
// self-checking bench for the resolver position host
`timescale 1ns/100ps
module resolver_host_bench;
   reg         clk, rst, readReq, phaseA, phaseB, dirIn, useDirPin;
   reg  [1:0]  readMode, readAddr, pos;
   reg  [47:0] angles;
   reg  [11:0] expCount;
   wire        readBusy, readDone_r, sclk_r, dataIn, dataEn, stepUp, stepDown;
   wire [11:0] angle_r, count;
   wire [3:0]  selectN;
   integer     n_mismatch, comparisons, rises, m;
   resolver_host i_dut (.clk(clk), .rst(rst), .readReq(readReq), .readMode(readMode),
      .readAddr(readAddr), .readBusy(readBusy), .readDone_r(readDone_r), .angle_r(angle_r),
      .sclk_r(sclk_r), .selectN(selectN), .dataIn(dataIn), .phaseA(phaseA), .phaseB(phaseB),
      .dirIn(dirIn), .useDirPin(useDirPin), .count(count), .stepUp(stepUp), .stepDown(stepDown));
   resolver_device i_dev (.selectN(selectN), .sclk(sclk_r), .angles(angles),
      .dataOut(dataIn), .dataEn(dataEn));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge sclk_r) rises = rises + 1;
   task check(input string name, input [15:0] seen, input [15:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task test_done;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // bounded wait on a flag; running out ends the run as a failure
   task waitFor(input reg want, input bit onDone);
      integer i;
      for (i = 0; i < 2000 && (onDone ? readDone_r : readBusy) !== want; i = i + 1)
         @(negedge clk);
      if (i == 2000) begin
         n_mismatch = n_mismatch + 1;
         test_done;
      end
   endtask
   task read(input [1:0] mode, input [1:0] addr, input [11:0] ang, input [4:0] nBits);
      waitFor(1'b0, 1'b0);
      angles[addr*12 +: 12] = ang;
      readMode = mode;
      readAddr = addr;
      readReq = 1'b1;
      rises = 0;
      @(negedge clk) readReq = 1'b0;
      check("select", {12'h000, selectN}, {12'h000, 4'hf & ~(4'h1 << addr)});
      waitFor(1'b1, 1'b1);
      check("angle", {4'h0, angle_r}, {4'h0, ang});
      check("bits", rises[15:0], {11'h000, nBits});
   endtask
   // one phase edge, B leading A for increasing angle, then the count is compared
   task walk(input bit fwd, input bit cntUp, input integer n);
      integer i;
      for (i = 0; i < n; i = i + 1) begin
         pos = fwd ? pos + 2'h1 : pos - 2'h1;
         expCount = cntUp ? expCount + 12'h001 : expCount - 12'h001;
         @(negedge clk) {phaseA, phaseB} = (pos == 2'h0) ? 2'b01 : (pos == 2'h1) ? 2'b11 :
            (pos == 2'h2) ? 2'b10 : 2'b00;
         repeat (6) @(negedge clk);
         check("count", {4'h0, count}, {4'h0, expCount});
      end
   endtask
   initial begin
      {rst, readReq, phaseA, phaseB, dirIn, useDirPin} = 6'b100000;
      {readMode, readAddr, angles, expCount, pos} = 0;
      pos = 2'h3; // both phases low is the last quarter of a cycle
      n_mismatch = 0;
      comparisons = 0;
      rises = 0;
      repeat (8) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      check("idle", {11'h000, selectN, sclk_r}, 16'h001f);
      // every mode on its own select, back to back, mode 3 behaves as mode 0
      // clock pulses per frame: the void bit of the inverted styles needs none
      for (m = 0; m < 4; m = m + 1)
         read(m[1:0], m[1:0], 12'ha5c ^ m[11:0] * 12'h3f1,
              (m == 1) ? 5'h0c : (m == 2) ? 5'h0f : 5'h10);
      read(2'h1, 2'h3, 12'hfff, 5'h0c);
      // a request during a frame is dropped
      angles[11:0] = 12'h801;
      read(2'h2, 2'h0, 12'h801, 5'h0f);
      waitFor(1'b0, 1'b0);
      readReq = 1'b1;
      repeat (100) @(negedge clk) readReq = 1'b1;
      readReq = 1'b0;
      waitFor(1'b1, 1'b1);
      repeat (60) @(negedge clk);
      check("refused", {14'h0000, readBusy, readDone_r}, 16'h0000);
      $display("serial read test done");
      walk(1'b1, 1'b1, 8);
      walk(1'b0, 1'b0, 12);
      useDirPin = 1'b1;
      walk(1'b1, 1'b0, 4);
      dirIn = 1'b1;
      walk(1'b0, 1'b1, 4);
      $display("quadrature test done");
      test_done;
   end
endmodule

// File: verification/resolver_host_props.sv
// assertion checker for the resolver position host ports
`timescale 1ns/100ps
module resolver_host_props (
   input wire        clk,
   input wire        rst,
   input wire        readBusy,
   input wire        readDone_r,
   input wire        sclk_r,
   input wire [3:0]  selectN,
   input wire        phaseA,
   input wire        phaseB,
   input wire [11:0] count,
   input wire        stepUp,
   input wire        stepDown
);
   reg  [5:0] lowCnt_r, highCnt_r, halfCnt_r;
   wire       idle = &selectN;
   // saturating cycle counters: frame age, idle age, time since last shift clock edge
   always @(posedge clk) begin
      lowCnt_r  <= (rst || idle) ? 6'h00 : lowCnt_r + {5'h00, ~&lowCnt_r};
      highCnt_r <= rst ? 6'h3f : (!idle ? 6'h00 : highCnt_r + {5'h00, ~&highCnt_r});
      halfCnt_r <= (rst || $changed(sclk_r)) ? 6'h00 : halfCnt_r + {5'h00, ~&halfCnt_r};
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_one_select: assert property ($onehot0(~selectN)) else $error("two selects low");
   a_clock_gated: assert property (idle |-> sclk_r) else $error("clock outside frame");
   a_setup_gap: assert property ($fell(sclk_r) |-> !idle && lowCnt_r >= 6'h18)
      else $error("clock too soon after select");
   a_half_period: assert property (!idle && $changed(sclk_r) |-> halfCnt_r >= 6'h09)
      else $error("shift clock too fast");
   a_select_hold: assert property ($rose(idle) |-> sclk_r && halfCnt_r >= 6'h0d)
      else $error("select released too early");
   a_idle_gap: assert property ($fell(idle) |-> highCnt_r >= 6'h0a)
      else $error("select idle gap too short");
   a_done_release: assert property (readDone_r |-> $rose(idle) ##1 !readDone_r)
      else $error("done not tied to frame end");
   a_busy_frame: assert property (!idle |-> readBusy) else $error("frame without busy");
   a_count_up: assert property (stepUp |-> !stepDown && count == $past(count) + 12'h001)
      else $error("bad up count");
   a_count_down: assert property (stepDown |-> count == $past(count) - 12'h001)
      else $error("bad down count");
   a_count_cause: assert property ($changed(count) |-> stepUp || stepDown)
      else $error("count moved without step");
   a_sync_delay: assert property (stepUp || stepDown |->
      $past(phaseA, 2) != $past(phaseA, 4) || $past(phaseB, 2) != $past(phaseB, 4))
      else $error("step without phase edge");
endmodule
bind resolver_host resolver_host_props i_props (.clk(clk), .rst(rst), .readBusy(readBusy),
   .readDone_r(readDone_r), .sclk_r(sclk_r), .selectN(selectN), .phaseA(phaseA),
   .phaseB(phaseB), .count(count), .stepUp(stepUp), .stepDown(stepDown));
